// [fpm_defs.svh]
// Constants of the floppy controller power manager: register offsets, bit positions, timing.
// Assumes inclusion by the package and the design files by bare name.
`ifndef FPM_DEFS_SVH
`define FPM_DEFS_SVH

// ----------------------------------------------------------------
// Host register offsets (3-bit address)
// ----------------------------------------------------------------
`define FPM_ADDR_STATUS_A 3'h0
`define FPM_ADDR_STATUS_B 3'h1
`define FPM_ADDR_OUTPUT_CTRL 3'h2
`define FPM_ADDR_MAIN_STATUS 3'h4
`define FPM_ADDR_DATA_RATE 3'h4
`define FPM_ADDR_FIFO 3'h5

// ----------------------------------------------------------------
// Field positions and the idle main-status value
// ----------------------------------------------------------------
`define FPM_DRATE_RESET_BIT 7
`define FPM_DRATE_SLEEP_BIT 6
`define FPM_DRATE_OSC_OFF_BIT 5
`define FPM_DOR_RESET_N_BIT 2
`define FPM_DOR_MOTOR_LO 4
`define FPM_IDLE_STATUS 8'h80

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define FPM_DOR_RESET_VAL 8'h00
`define FPM_DRATE_RESET_VAL 8'h02

// ----------------------------------------------------------------
// Timing (clock 200 MHz)
// ----------------------------------------------------------------
`define FPM_CLK_HZ 200000000
`define FPM_SHORT_DELAY_US 10000
`define FPM_LONG_DELAY_US 500000
`define FPM_DRATE_EXTEND_US 10000
`define FPM_US_TO_CYCLES(us) ((us) * (`FPM_CLK_HZ / 1000000))

`endif

// [fpm_pkg.sv]
// Types of the floppy controller power manager.
// Assumes fpm_defs.svh is available for inclusion.
`include "fpm_defs.svh"

package fpm_pkg;

	typedef enum logic [1:0] {
		FPM_AWAKE,
		FPM_AUTO_SLEEP,
		FPM_DIRECT_SLEEP
	} fpm_state_e;

	typedef logic [27:0] fpm_count_t;

endpackage : fpm_pkg

// [fpm_timer.sv]
// Down counter used as the auto powerdown timer.
// Assumes load and extend come from the same clock domain.
`timescale 1ns/1ps

module fpm_timer #(
	parameter int WIDTH = 28
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic load_in,
	input wire logic [WIDTH-1:0] load_value_in,
	input wire logic extend_in,
	input wire logic [WIDTH-1:0] extend_value_in,
	input wire logic cancel_in,
	output logic running_out,
	output logic expired_out
);

	initial begin
		if (WIDTH < 8) begin
			$error("fpm_timer: WIDTH too small");
		end
	end

	typedef struct packed {
		logic [WIDTH-1:0] count;
		logic running;
		logic expired;
	} fpm_timer_s;

	fpm_timer_s state_reg;
	fpm_timer_s state_next;

	function automatic logic [WIDTH-1:0] fpm_sat_add(input logic [WIDTH-1:0] a,
		input logic [WIDTH-1:0] b);
		logic [WIDTH:0] sum;
		sum = {1'b0, a} + {1'b0, b};
		fpm_sat_add = sum[WIDTH] ? '1 : sum[WIDTH-1:0];
	endfunction : fpm_sat_add

	always_comb begin
		state_next = state_reg;
		if (cancel_in) begin
			state_next.count = '0;
			state_next.running = 1'b0;
			state_next.expired = 1'b0;
		end else if (load_in) begin
			state_next.count = load_value_in;
			state_next.running = 1'b1;
			state_next.expired = 1'b0;
		end else if (state_reg.running) begin
			// Extension only applies while counting down
			if (extend_in) begin
				state_next.count = fpm_sat_add(state_reg.count, extend_value_in);
			end else if (state_reg.count <= WIDTH'(1)) begin
				state_next.count = '0;
				state_next.running = 1'b0;
				state_next.expired = 1'b1;
			end else begin
				state_next.count = state_reg.count - WIDTH'(1);
			end
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign running_out = state_reg.running;
	assign expired_out = state_reg.expired;

endmodule : fpm_timer

// [fpm_power_manager.sv]
// Power manager of a floppy controller: oscillator control, direct and auto powerdown, wake.
// Assumes host strobes are synchronous one-cycle pulses; core status arrives on this clock.
`timescale 1ns/1ps

`include "fpm_defs.svh"

module fpm_power_manager #(
	parameter int SHORT_DELAY_CYCLES = `FPM_US_TO_CYCLES(`FPM_SHORT_DELAY_US),
	parameter int LONG_DELAY_CYCLES = `FPM_US_TO_CYCLES(`FPM_LONG_DELAY_US),
	parameter int EXTEND_CYCLES = `FPM_US_TO_CYCLES(`FPM_DRATE_EXTEND_US),
	parameter int POLL_DELAY_CYCLES = 64
) (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [2:0] host_addr_in,
	input wire logic host_rd_in,
	input wire logic host_wr_in,
	input wire logic [7:0] host_wdata_in,
	input wire logic cmd_pd_valid_in,
	input wire logic cmd_auto_enable_in,
	input wire logic cmd_min_delay_in,
	input wire logic [7:0] main_status_in,
	input wire logic core_int_in,
	input wire logic head_unloaded_in,
	input wire logic fifo_lock_in,
	input wire logic [5:0] drive_inputs_in,
	input wire logic [7:0] status_a_in,
	input wire logic [7:0] status_b_in,
	output logic [7:0] host_rdata_out,
	output logic [7:0] output_ctrl_out,
	output logic [1:0] data_rate_out,
	output logic [3:0] motor_enables_out,
	output logic drive_out_oe_n_out,
	output logic [5:0] drive_inputs_out,
	output logic osc_enable_out,
	output logic sleep_status_out,
	output logic idle_out,
	output logic core_reset_out,
	output logic fifo_reset_out,
	output logic poll_int_req_out
);

	localparam int CW = 28;

	initial begin
		if (LONG_DELAY_CYCLES >= (1 << CW) || SHORT_DELAY_CYCLES < 1 ||
			EXTEND_CYCLES < 1 || POLL_DELAY_CYCLES < 1 || POLL_DELAY_CYCLES > 255) begin
			$error("fpm_power_manager: delay parameter out of range");
		end
	end

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		fpm_pkg::fpm_state_e mode;
		logic [7:0] output_ctrl;
		logic [7:0] data_rate;
		logic auto_enable;
		logic min_delay;
		logic [7:0] poll_count;
		logic poll_pending;
		logic [7:0] rdata;
		logic core_reset;
		logic fifo_reset;
		logic poll_int;
		logic osc_enable;
		logic sleep_status;
		logic idle;
		logic drive_oe_n;
		logic [5:0] drive_inputs;
		logic [5:0] drive_sync1;
		logic [5:0] drive_sync2;
	} fpm_state_s;

	fpm_state_s state_reg;
	fpm_state_s state_next;

	logic timer_load;
	logic timer_cancel;
	logic timer_extend;
	logic timer_running;
	logic timer_expired;
	fpm_pkg::fpm_count_t timer_value;

	function automatic fpm_pkg::fpm_count_t fpm_min_delay(input logic long_sel);
		fpm_min_delay = long_sel ? CW'(LONG_DELAY_CYCLES) : CW'(SHORT_DELAY_CYCLES);
	endfunction : fpm_min_delay

	fpm_timer #(
		.WIDTH(CW)
	) u_timer (
		.clk_sys_in(clk_sys_in),
		.reset_in(reset_in),
		.load_in(timer_load),
		.load_value_in(timer_value),
		.extend_in(timer_extend),
		.extend_value_in(CW'(EXTEND_CYCLES)),
		.cancel_in(timer_cancel),
		.running_out(timer_running),
		.expired_out(timer_expired)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		logic wr_dor;
		logic wr_dsr;
		logic sw_reset;
		logic dor_reset_held;
		logic access_wake;
		logic sleep_ok;
		logic asleep;
		logic [7:0] rd;

		state_next = state_reg;
		sw_reset = 1'b0;
		dor_reset_held = 1'b0;
		access_wake = 1'b0;
		sleep_ok = 1'b0;
		rd = 8'h00;
		wr_dor = host_wr_in && host_addr_in == `FPM_ADDR_OUTPUT_CTRL;
		wr_dsr = host_wr_in && host_addr_in == `FPM_ADDR_DATA_RATE;
		asleep = state_reg.mode != fpm_pkg::FPM_AWAKE;
		timer_load = 1'b0;
		timer_cancel = 1'b0;
		timer_extend = 1'b0;
		timer_value = fpm_min_delay(state_reg.min_delay);

		// Writes are always kept, even while asleep
		if (wr_dor) begin
			state_next.output_ctrl = host_wdata_in;
		end
		if (wr_dsr) begin
			// Self-clearing reset bit is never stored
			state_next.data_rate = host_wdata_in & 8'h7F;
			if (host_wdata_in[1:0] != state_reg.data_rate[1:0]) begin
				timer_extend = timer_running;
			end
		end

		// OUTPUT_CTRL_REG reset is active low and held; DSR reset is a pulse
		dor_reset_held = !state_next.output_ctrl[`FPM_DOR_RESET_N_BIT];
		sw_reset = dor_reset_held || (wr_dsr && host_wdata_in[`FPM_DRATE_RESET_BIT]);

		// Wake sources from auto sleep; status A/B and output-ctrl reads are not
		access_wake = (host_rd_in && host_addr_in == `FPM_ADDR_MAIN_STATUS) ||
			((host_rd_in || host_wr_in) && host_addr_in == `FPM_ADDR_FIFO) ||
			(wr_dor && host_wdata_in[7:`FPM_DOR_MOTOR_LO] != 4'h0);

		// Powerdown-mode command
		if (cmd_pd_valid_in) begin
			state_next.auto_enable = cmd_auto_enable_in;
			state_next.min_delay = cmd_min_delay_in;
			if (cmd_auto_enable_in) begin
				timer_load = 1'b1;
				timer_value = fpm_min_delay(cmd_min_delay_in);
			end else begin
				timer_cancel = 1'b1;
			end
		end

		sleep_ok = state_reg.auto_enable && state_reg.output_ctrl[7:4] == 4'h0 &&
			main_status_in == `FPM_IDLE_STATUS && !core_int_in &&
			head_unloaded_in && timer_expired;

		state_next.core_reset = 1'b0;
		state_next.fifo_reset = 1'b0;
		state_next.poll_int = 1'b0;

		if (wr_dsr && host_wdata_in[`FPM_DRATE_SLEEP_BIT] && !sw_reset) begin
			// Internal reset and sleep in the same cycle, whatever the current mode
			state_next.mode = fpm_pkg::FPM_DIRECT_SLEEP;
			state_next.core_reset = 1'b1;
			state_next.fifo_reset = !fifo_lock_in;
			state_next.poll_pending = 1'b0;
			timer_cancel = 1'b1;
		end else if (sw_reset) begin
			// Software reset wakes from either mode, keeps auto settings
			state_next.mode = fpm_pkg::FPM_AWAKE;
			state_next.core_reset = 1'b1;
			state_next.fifo_reset = !fifo_lock_in;
			state_next.poll_pending = 1'b1;
			state_next.poll_count = 8'(POLL_DELAY_CYCLES);
			timer_cancel = !state_reg.auto_enable;
			timer_load = state_reg.auto_enable;
		end else begin
			unique case (state_reg.mode)
				fpm_pkg::FPM_AWAKE: begin
					// A wake in the entry cycle keeps the device up
					if (access_wake && state_reg.auto_enable) begin
						timer_load = 1'b1;
					end else if (sleep_ok) begin
						state_next.mode = fpm_pkg::FPM_AUTO_SLEEP;
					end
				end
				fpm_pkg::FPM_AUTO_SLEEP: begin
					if (!state_reg.auto_enable) begin
						state_next.mode = fpm_pkg::FPM_AWAKE;
					end else if (access_wake) begin
						state_next.mode = fpm_pkg::FPM_AWAKE;
						timer_load = 1'b1;
					end
				end
				fpm_pkg::FPM_DIRECT_SLEEP: begin
					state_next.mode = fpm_pkg::FPM_DIRECT_SLEEP;
				end
				default: begin
					state_next.mode = fpm_pkg::FPM_AWAKE;
				end
			endcase
		end

		// Delayed polling interrupt after a waking reset
		if (state_next.poll_pending && !sw_reset) begin
			if (state_reg.poll_count <= 8'h01) begin
				state_next.poll_pending = 1'b0;
				state_next.poll_int = 1'b1;
			end else begin
				state_next.poll_count = state_reg.poll_count - 8'h01;
			end
		end

		// Host read data; reads are served in every mode
		unique case (host_addr_in)
			`FPM_ADDR_STATUS_A: rd = status_a_in;
			`FPM_ADDR_STATUS_B: rd = status_b_in;
			`FPM_ADDR_OUTPUT_CTRL: rd = state_reg.output_ctrl;
			`FPM_ADDR_MAIN_STATUS: rd = main_status_in;
			default: rd = 8'h00;
		endcase
		state_next.rdata = host_rd_in ? rd : state_reg.rdata;

		asleep = state_next.mode != fpm_pkg::FPM_AWAKE;
		state_next.osc_enable = !state_next.data_rate[`FPM_DRATE_OSC_OFF_BIT];
		state_next.sleep_status = asleep;
		state_next.idle = (state_next.mode == fpm_pkg::FPM_AUTO_SLEEP) ||
			(!asleep && main_status_in == `FPM_IDLE_STATUS && !core_int_in &&
			head_unloaded_in);
		state_next.drive_oe_n = asleep;
		// Drive pins are asynchronous to this clock; only the second stage is read
		state_next.drive_sync1 = drive_inputs_in;
		state_next.drive_sync2 = state_reg.drive_sync1;
		state_next.drive_inputs = asleep ? 6'h00 : state_reg.drive_sync2;
	end

	always_ff @(posedge clk_sys_in) begin
		if (reset_in) begin
			state_reg <= '0;
			state_reg.mode <= fpm_pkg::FPM_AWAKE;
			state_reg.output_ctrl <= `FPM_DOR_RESET_VAL;
			state_reg.data_rate <= `FPM_DRATE_RESET_VAL;
			state_reg.auto_enable <= 1'b0;
			state_reg.core_reset <= 1'b1;
			state_reg.fifo_reset <= 1'b1;
			state_reg.osc_enable <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign host_rdata_out = state_reg.rdata;
	assign output_ctrl_out = state_reg.output_ctrl;
	assign data_rate_out = state_reg.data_rate[1:0];
	assign motor_enables_out = state_reg.output_ctrl[7:4];
	assign drive_out_oe_n_out = state_reg.drive_oe_n;
	assign drive_inputs_out = state_reg.drive_inputs;
	assign osc_enable_out = state_reg.osc_enable;
	assign sleep_status_out = state_reg.sleep_status;
	assign idle_out = state_reg.idle;
	assign core_reset_out = state_reg.core_reset;
	assign fifo_reset_out = state_reg.fifo_reset;
	assign poll_int_req_out = state_reg.poll_int;

endmodule : fpm_power_manager

// [fpm_power_manager_props.sv]
// Checker for the floppy power manager: sleep entry, wake, pin release, oscillator.
// Assumes it is bound to fpm_power_manager and sees only that module's ports.
`timescale 1ns/1ps
module fpm_power_manager_props (
	input wire logic clk_sys_in,
	input wire logic reset_in,
	input wire logic [2:0] host_addr_in,
	input wire logic host_rd_in,
	input wire logic host_wr_in,
	input wire logic [7:0] host_wdata_in,
	input wire logic [7:0] main_status_in,
	input wire logic core_int_in,
	input wire logic head_unloaded_in,
	input wire logic [3:0] motor_enables_out,
	input wire logic [5:0] drive_inputs_out,
	input wire logic drive_out_oe_n_out,
	input wire logic osc_enable_out,
	input wire logic sleep_status_out,
	input wire logic idle_out,
	input wire logic core_reset_out,
	input wire logic poll_int_req_out
);
	default clocking cb @(posedge clk_sys_in);
	endclocking
	default disable iff (reset_in);
	logic dsr_wr;
	logic dor_rst_wr;
	logic wake_acc;
	assign dsr_wr = host_wr_in && host_addr_in == 3'h4;
	assign dor_rst_wr = host_wr_in && host_addr_in == 3'h2 && !host_wdata_in[2];
	assign wake_acc = (host_rd_in && host_addr_in == 3'h4)
		|| ((host_rd_in || host_wr_in) && host_addr_in == 3'h5)
		|| (host_wr_in && host_addr_in == 3'h2 && host_wdata_in[7:4] != 4'h0);
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	osc_follow_a: assert property (
		dsr_wr |=> osc_enable_out == !$past(host_wdata_in[5]))
		else $error("osc enable does not follow the osc-off bit");
	osc_hold_a: assert property (
		!dsr_wr |=> $stable(osc_enable_out))
		else $error("osc enable moved without a rate write");
	direct_entry_a: assert property (
		dsr_wr && host_wdata_in[7:6] == 2'b01 && !core_reset_out
		|=> sleep_status_out && !idle_out && core_reset_out)
		else $error("direct sleep not entered with reset");
	direct_hold_a: assert property (
		sleep_status_out && !idle_out && !(dsr_wr && host_wdata_in[7]) && !dor_rst_wr
		|=> sleep_status_out && !idle_out)
		else $error("direct sleep left without reset");
	reset_wake_a: assert property (
		dsr_wr && host_wdata_in[7] |=> !sleep_status_out)
		else $error("software reset did not wake");
	quiet_read_a: assert property (
		sleep_status_out && host_rd_in && host_addr_in <= 3'h2 |=> sleep_status_out)
		else $error("status read woke the device");
	wake_access_a: assert property (
		sleep_status_out && idle_out && wake_acc |=> !sleep_status_out)
		else $error("wake access ignored in auto sleep");
	pins_off_a: assert property (
		sleep_status_out |-> drive_out_oe_n_out && drive_inputs_out == 6'h00)
		else $error("drive pins active while asleep");
	auto_entry_a: assert property (
		$rose(sleep_status_out) && idle_out |-> $past(motor_enables_out) == 4'h0
		&& $past(main_status_in) == 8'h80 && !$past(core_int_in)
		&& $past(head_unloaded_in))
		else $error("auto sleep entered while not idle");
	poll_pulse_a: assert property (
		poll_int_req_out |=> !poll_int_req_out)
		else $error("poll request longer than one cycle");
	auto_sleep_c: cover property ($rose(sleep_status_out) && idle_out);
	direct_sleep_c: cover property ($rose(sleep_status_out) && !idle_out);
	wake_c: cover property ($fell(sleep_status_out));
endmodule : fpm_power_manager_props

bind fpm_power_manager fpm_power_manager_props chk_u (.*);

// [fpm_host_model.sv]
// Host model: single-byte register reads and writes on the strobe port.
// Assumes one clock; strobes change on the falling edge and last one cycle.
`timescale 1ns/1ps
module fpm_host_model (
	input wire logic clk_sys_in,
	input wire logic [7:0] host_rdata_in,
	output logic [2:0] host_addr_out = 3'h0,
	output logic host_rd_out = 1'b0,
	output logic host_wr_out = 1'b0,
	output logic [7:0] host_wdata_out = 8'h00
);
	// Released lines show the inverse so a stale value never passes for a live one
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(negedge clk_sys_in);
		host_addr_out = a;
		host_wdata_out = d;
		host_wr_out = 1'b1;
		@(negedge clk_sys_in);
		host_wr_out = 1'b0;
		host_addr_out = ~a;
		host_wdata_out = ~d;
	endtask : wr
	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(negedge clk_sys_in);
		host_addr_out = a;
		host_rd_out = 1'b1;
		@(negedge clk_sys_in);
		host_rd_out = 1'b0;
		host_addr_out = ~a;
		@(negedge clk_sys_in);
		d = host_rdata_in;
	endtask : rd
endmodule : fpm_host_model

// [fpm_power_manager_tb_top.sv]
// Testbench of the power manager: direct and auto sleep, wake paths, resets.
// Assumes the host model drives the strobes; other inputs change on the falling edge.
`timescale 1ns/1ps
module fpm_power_manager_tb_top;
	localparam int SHORT = 20;
	localparam int LONG = 50;
	localparam int EXT = 10;
	logic clk_sys_in = 1'b0;
	logic reset_in = 1'b1;
	logic [2:0] host_addr_in;
	logic host_rd_in;
	logic host_wr_in;
	logic [7:0] host_wdata_in;
	logic cmd_pd_valid_in = 1'b0;
	logic cmd_auto_enable_in = 1'b0;
	logic cmd_min_delay_in = 1'b0;
	logic [7:0] main_status_in = 8'h80;
	logic core_int_in = 1'b0;
	logic head_unloaded_in = 1'b1;
	logic fifo_lock_in = 1'b0;
	logic [5:0] drive_inputs_in = 6'h2a;
	logic [7:0] status_a_in = 8'h5a;
	logic [7:0] status_b_in = 8'ha5;
	logic [7:0] host_rdata_out;
	logic [7:0] output_ctrl_out;
	logic [1:0] data_rate_out;
	logic [3:0] motor_enables_out;
	logic drive_out_oe_n_out;
	logic [5:0] drive_inputs_out;
	logic osc_enable_out;
	logic sleep_status_out;
	logic idle_out;
	logic core_reset_out;
	logic fifo_reset_out;
	logic poll_int_req_out;
	int fail_count = 0;
	int n_tests = 0;
	logic [7:0] rdat;
	// Access table entries: write flag, address, data
	logic [11:0] quiet [5] = '{12'h000, 12'h100, 12'h200, 12'ha04, 12'hc02};
	logic [11:0] wake [4] = '{12'h400, 12'h500, 12'hd00, 12'ha14};

	always #2.5 clk_sys_in = ~clk_sys_in;
	fpm_power_manager #(.SHORT_DELAY_CYCLES(SHORT), .LONG_DELAY_CYCLES(LONG),
		.EXTEND_CYCLES(EXT), .POLL_DELAY_CYCLES(8)) dut_u (.*);
	fpm_host_model host_u (.clk_sys_in(clk_sys_in), .host_rdata_in(host_rdata_out),
		.host_addr_out(host_addr_in), .host_rd_out(host_rd_in),
		.host_wr_out(host_wr_in), .host_wdata_out(host_wdata_in));
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		n_tests++;
		if (got !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, got);
			fail_count++;
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys_in);
	endtask : cyc
	task automatic cmd(input logic auto_en, input logic min_awake_select);
		@(negedge clk_sys_in);
		cmd_pd_valid_in = 1'b1;
		cmd_auto_enable_in = auto_en;
		cmd_min_delay_in = min_awake_select;
		@(negedge clk_sys_in);
		cmd_pd_valid_in = 1'b0;
	endtask : cmd
	task automatic acc(input logic [11:0] a);
		if (a[11]) host_u.wr(a[10:8], a[7:0]);
		else host_u.rd(a[10:8], rdat);
	endtask : acc
	// Bounded wait so a design that never sleeps cannot hang the run
	task automatic to_sleep(output int n);
		n = 0;
		while (sleep_status_out !== 1'b1 && n < 300) begin
			cyc(1);
			n++;
		end
	endtask : to_sleep
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : tally_and_finish
	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_direct;
		int n;
		chk("output ctrl", 8'h00, output_ctrl_out);
		chk("reset held", 8'h01, 8'(core_reset_out));
		host_u.wr(3'h2, 8'h04);
		host_u.wr(3'h4, 8'h22);
		chk("osc off", 8'h00, 8'(osc_enable_out));
		host_u.wr(3'h4, 8'h42);
		chk("direct sleep", 8'h01, 8'(sleep_status_out));
		chk("direct idle", 8'h00, 8'(idle_out));
		chk("osc on", 8'h01, 8'(osc_enable_out));
		chk("drive oe", 8'h01, 8'(drive_out_oe_n_out));
		chk("drive in asleep", 8'h00, 8'(drive_inputs_out));
		host_u.rd(3'h5, rdat);
		host_u.wr(3'h2, 8'h14);
		host_u.rd(3'h0, rdat);
		chk("status a", status_a_in, rdat);
		chk("no wake", 8'h01, 8'(sleep_status_out));
		host_u.wr(3'h4, 8'h82);
		chk("reset wake", 8'h00, 8'(sleep_status_out));
		chk("held motor", 8'h01, 8'(motor_enables_out));
		chk("drive in awake", 8'h2a, 8'(drive_inputs_out));
		n = 0;
		while (poll_int_req_out !== 1'b1 && n < 40) begin
			cyc(1);
			n++;
		end
		chk("poll", 8'h01, 8'(poll_int_req_out));
		host_u.wr(3'h2, 8'h04);
		$display("test direct done");
	endtask : t_direct
	task automatic t_auto;
		int n;
		cmd(1'b1, 1'b0);
		to_sleep(n);
		chk("first delay", 8'h01, 8'(n >= SHORT - 4 && n <= SHORT + 6));
		chk("auto idle", 8'h01, 8'(idle_out));
		for (int i = 0; i < 5; i++) begin
			acc(quiet[i]);
			chk("quiet access", 8'h01, 8'(sleep_status_out));
		end
		for (int i = 0; i < 4; i++) begin
			acc(wake[i]);
			chk("wake access", 8'h00, 8'(sleep_status_out));
			if (i == 3) begin
				cyc(40);
				chk("motor on", 8'h00, 8'(sleep_status_out));
				host_u.wr(3'h2, 8'h04);
			end
			to_sleep(n);
			chk("rearm", 8'h01, 8'(n <= SHORT + 6 && (i == 3 || n >= SHORT - 4)));
		end
		for (int i = 0; i < 3; i++) begin
			host_u.rd(3'h4, rdat);
			core_int_in = (i == 0);
			head_unloaded_in = (i != 1);
			main_status_in = (i == 2) ? 8'h81 : 8'h80;
			cyc(60);
			chk("held awake", 8'h00, 8'(sleep_status_out));
			core_int_in = 1'b0;
			head_unloaded_in = 1'b1;
			main_status_in = 8'h80;
			to_sleep(n);
			chk("idle sleep", 8'h01, 8'(sleep_status_out));
		end
		$display("test auto done");
	endtask : t_auto
	task automatic t_timing;
		int n;
		host_u.rd(3'h4, rdat);
		chk("main status", 8'h80, rdat);
		host_u.wr(3'h4, 8'h01);
		chk("rate", 8'h01, 8'(data_rate_out));
		to_sleep(n);
		chk("rate extend", 8'h01, 8'(n >= SHORT + EXT - 8));
		host_u.rd(3'h4, rdat);
		cmd(1'b1, 1'b1);
		to_sleep(n);
		chk("long delay", 8'h01, 8'(n >= LONG - 4 && n <= LONG + 6));
		cmd(1'b0, 1'b0);
		cyc(100);
		chk("disabled", 8'h00, 8'(sleep_status_out));
		cmd(1'b1, 1'b0);
		to_sleep(n);
		host_u.wr(3'h4, 8'h41);
		chk("override", 8'h00, 8'(idle_out));
		host_u.wr(3'h2, 8'h00);
		chk("dor wake", 8'h00, 8'(sleep_status_out));
		chk("fifo reset", 8'h01, 8'(fifo_reset_out));
		host_u.wr(3'h2, 8'h04);
		to_sleep(n);
		chk("auto kept", 8'h01, 8'(idle_out && n <= SHORT + 6));
		reset_in = 1'b1;
		cyc(6);
		reset_in = 1'b0;
		host_u.wr(3'h2, 8'h04);
		cyc(SHORT + 40);
		chk("hw reset auto off", 8'h00, 8'(sleep_status_out));
		$display("test timing done");
	endtask : t_timing

	initial begin
		cyc(6);
		reset_in = 1'b0;
		t_direct();
		t_auto();
		t_timing();
		tally_and_finish();
	end
	initial begin
		cyc(6000);
		fail_count++;
		tally_and_finish();
	end
endmodule : fpm_power_manager_tb_top
